// *** tb_top.sv ***
// Self-checking bench for the serial slice and its controller joined back to back.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ufb_pkg::*;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, cw;
   logic [3:0] s_axi_wstrb = STRB_ALL;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_pin, rx_line, tx_empty_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [33:0] f, f2;
   logic [8:0] d, d2;
   logic [6:0] c;
   logic [6:0] cfg [3] = '{7'h00, 7'h1e, 7'h65};
   int n_errors = 0, n_checks = 0, seed = 98, dv, dl, n;
   time t0, tf;
   always #10 mclk = ~mclk;
   ufb_if lnk();
   ufb_dev ufb_dev_inst(.mclk, .srst, .bus(lnk), .tx_pin, .serial_clock_pin(), .cts_n(1'b0), .rx_pin(tx_pin),
      .rx_line, .os_tick(), .rx_word_valid(1'b0), .rx_word(9'h000), .tx_empty_irq);
   ufb_ctl ufb_ctl_inst(.bus(lnk), .*);
   ufb_link_checker ufb_link_checker_inst(.mclk, .srst, .reg_addr(lnk.reg_addr), .reg_wr(lnk.reg_wr),
      .reg_rd(lnk.reg_rd), .reg_wdata(lnk.reg_wdata), .reg_rvalid(lnk.reg_rvalid),
      .tx_dma_req(lnk.tx_dma_req), .tx_done(lnk.tx_done), .ctrl_view(lnk.ctrl_view));
   // ==========
   // Tasks. Each bus task starts on a fresh edge so no signal is driven twice in one step.
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [31:0] dw, input logic [1:0] er);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dw;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk({32'h0, s_axi_bresp}, {32'h0, er});
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [33:0] exp);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk({s_axi_rresp, s_axi_rdata}, exp);
   endtask : rd
   task automatic grab(output logic [33:0] fv);
      fv = 34'h0;
      @(negedge tx_pin);
      tf = $time;
      repeat (dv / 2) @(posedge mclk);
      for (int i = 0; i < dl + 2; i++) begin
         fv[i] = tx_pin;
         chk(34'(rx_line), 34'(tx_pin));
         if (i < dl + 1) repeat (dv) @(posedge mclk);
      end
   endtask : grab
   // Expected line bits, start first; parity and inversion follow the frame settings.
   function automatic logic [33:0] frame(input logic [8:0] dw, input int nd, input logic [6:0] k);
      logic [8:0] w;
      logic [33:0] fv;
      w = dw & ((9'h001 << (nd - 32'(k[2]))) - 9'h001);
      if (k[2]) w[nd - 1] = ^w ^ k[3];
      if (k[5]) w = ~w;
      fv = 34'h0;
      for (int i = 0; i < nd; i++) fv[i + 1] = k[4] ? w[nd - 1 - i] : w[i];
      fv[nd + 1] = 1'b1;
      return fv;
   endfunction : frame
   task automatic test_done;
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (40000) @(posedge mclk);
      n_errors++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      rd(5'h00, {RESP_OKAY, 32'h0});
      rd(5'h08, {RESP_OKAY, 32'h3});
      rd(5'h18, {RESP_SLVERR, 32'h0});
      wr(5'h04, 32'h0000_000f, RESP_SLVERR);
      dv = 16 + ($random(seed) & 7);
      wr(5'h04, 32'(dv), RESP_OKAY);
      for (int i = 0; i < 3; i++) begin
         c = cfg[i];
         dl = c[1:0] == DL_7 ? 7 : c[1:0] == DL_9 ? 9 : 8;
         cw = {17'h0, c[6], 2'h0, c[5:2], 2'h0, c[1:0], 4'h3};
         wr(5'h00, cw, RESP_OKAY);
         t0 = $time;
         d = 9'($random(seed));
         wr(c[6] ? 5'h10 : 5'h0c, {23'h0, d}, RESP_OKAY);
         grab(f);
         chk(f, frame(d, dl, c));
         if (i == 0) chk(34'(tf - t0 >= (10 * dv - 2) * 20), 34'h1);
         repeat (dv) @(posedge mclk);
      end
      wr(5'h04, 32'h0000_0020, RESP_SLVERR);
      rd(5'h04, {RESP_OKAY, 32'(dv)});
      rd(5'h08, {RESP_OKAY, 32'h3});
      d = 9'($random(seed));
      d2 = 9'($random(seed));
      fork
         begin
            grab(f);
            grab(f2);
         end
         begin
            wr(5'h0c, {23'h0, d}, RESP_OKAY);
            repeat (dv) @(posedge mclk);
            wr(5'h0c, {23'h0, d2}, RESP_OKAY);
            wr(5'h00, 32'h0, RESP_SLVERR);
            rd(5'h08, {RESP_OKAY, 32'h0});
         end
      join
      chk(f, frame(d, dl, c));
      chk(f2, frame(d2, dl, c));
      repeat (dv) @(posedge mclk);
      rd(5'h08, {RESP_OKAY, 32'h3});
      fork
         wr(5'h00, cw | 32'h0003_0000, RESP_OKAY);
         begin
            @(negedge tx_pin);
            n = 0;
            while (tx_pin === 1'b0) begin
               @(posedge mclk);
               #1;
               n++;
            end
         end
      join
      chk(34'(n), 34'((2 + dl) * dv));
      chk(34'(tx_empty_irq), 34'h1);
      repeat (2 * dv) @(posedge mclk);
      wr(5'h00, 32'h0, RESP_OKAY);
      rd(5'h08, {RESP_OKAY, 32'h7});
      wr(5'h08, 32'h0, RESP_OKAY);
      rd(5'h08, {RESP_OKAY, 32'h3});
      test_done();
   end
endmodule : tb_top
`default_nettype wire

// *** ufb_ctl.sv ***
// Controller: AXI4-Lite window onto the slice, guarded writes and DMA service.
`timescale 1ns/1ps
`default_nettype none
module ufb_ctl (
   input wire logic mclk,
   input wire logic srst,
   ufb_if.ctl bus,
   input wire logic [ufb_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ufb_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import ufb_pkg::*;
   typedef enum logic [2:0] {C_IDLE, C_WTAKE, C_WRESP, C_RTAKE, C_RWAIT, C_RRESP} ufb_ctl_state_t;

   ufb_ctl_state_t st_reg;
   logic [31:0] txw_reg;
   logic txf_reg, dma_rd_reg, rxv_reg, bad;
   logic [DATA_W-1:0] rxw_reg;
   logic [31:0] cv;
   logic [1:0] idx;

   assign cv = bus.ctrl_view;
   assign idx = s_axi_awaddr[3:2];

   // =====================================================
   // Write guard: refused writes answer SLVERR and never reach the slice.
   always_comb begin
      bad = s_axi_wstrb != STRB_ALL;
      if (s_axi_awaddr[A_LOCAL_BIT]) begin
         bad = bad || s_axi_awaddr != A_DMA_TX || txf_reg;
      end else if (idx == IDX_BAUD) begin
         bad = bad || cv[C_PERIPH] || s_axi_wdata[15:0] < MIN_DIV;
      end else if (idx == IDX_CTRL) begin
         bad = bad || (!bus.tx_done && ((cv[C_PERIPH] && !s_axi_wdata[C_PERIPH])
            || (cv[C_TXON] && !s_axi_wdata[C_TXON])));
      end
   end

   // =====================================================
   // Bus engine
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_reg <= C_IDLE;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
         bus.reg_wr <= 1'b0;
         bus.reg_rd <= 1'b0;
         bus.reg_addr <= IDX_CTRL;
         bus.reg_wdata <= '0;
         txw_reg <= '0;
         txf_reg <= 1'b0;
         rxw_reg <= '0;
         rxv_reg <= 1'b0;
         dma_rd_reg <= 1'b0;
      end else begin
         bus.reg_wr <= 1'b0;
         bus.reg_rd <= 1'b0;
         unique case (st_reg)
            C_IDLE: begin
               if (s_axi_awvalid && s_axi_wvalid) begin
                  s_axi_awready <= 1'b1;
                  s_axi_wready <= 1'b1;
                  st_reg <= C_WTAKE;
               end else if (s_axi_arvalid) begin
                  s_axi_arready <= 1'b1;
                  st_reg <= C_RTAKE;
               end else if (txf_reg && bus.tx_dma_req) begin
                  bus.reg_addr <= IDX_DATA;
                  bus.reg_wdata <= txw_reg;
                  bus.reg_wr <= 1'b1;
                  txf_reg <= 1'b0;
               end else if (!rxv_reg && bus.rx_dma_req) begin
                  bus.reg_addr <= IDX_DATA;
                  bus.reg_rd <= 1'b1;
                  dma_rd_reg <= 1'b1;
                  st_reg <= C_RWAIT;
               end
            end
            C_WTAKE: begin
               s_axi_awready <= 1'b0;
               s_axi_wready <= 1'b0;
               s_axi_bvalid <= 1'b1;
               s_axi_bresp <= bad ? RESP_SLVERR : RESP_OKAY;
               if (!bad && s_axi_awaddr[A_LOCAL_BIT]) begin
                  txw_reg <= s_axi_wdata;
                  txf_reg <= 1'b1;
               end else if (!bad) begin
                  bus.reg_addr <= idx;
                  bus.reg_wdata <= s_axi_wdata;
                  bus.reg_wr <= 1'b1;
               end
               st_reg <= C_WRESP;
            end
            C_WRESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  st_reg <= C_IDLE;
               end
            end
            C_RTAKE: begin
               s_axi_arready <= 1'b0;
               s_axi_rresp <= RESP_OKAY;
               st_reg <= C_RRESP;
               s_axi_rvalid <= 1'b1;
               if (!s_axi_araddr[A_LOCAL_BIT]) begin
                  bus.reg_addr <= s_axi_araddr[3:2];
                  bus.reg_rd <= 1'b1;
                  s_axi_rvalid <= 1'b0;
                  st_reg <= C_RWAIT;
               end else if (s_axi_araddr == A_DMA_TX) begin
                  s_axi_rdata <= 32'(txf_reg);
               end else if (s_axi_araddr == A_DMA_RX) begin
                  s_axi_rdata <= 32'(rxw_reg);
                  s_axi_rdata[RXV_BIT] <= rxv_reg;
                  rxv_reg <= 1'b0;
               end else begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= RESP_SLVERR;
               end
            end
            C_RWAIT: begin
               if (bus.reg_rvalid && dma_rd_reg) begin
                  rxw_reg <= bus.reg_rdata[DATA_W-1:0];
                  rxv_reg <= 1'b1;
                  dma_rd_reg <= 1'b0;
                  st_reg <= C_IDLE;
               end else if (bus.reg_rvalid) begin
                  s_axi_rdata <= bus.reg_rdata;
                  s_axi_rvalid <= 1'b1;
                  st_reg <= C_RRESP;
               end
            end
            C_RRESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  st_reg <= C_IDLE;
               end
            end
         endcase
      end
   end
endmodule : ufb_ctl
`default_nettype wire

// *** ufb_dev.sv ***
// Serial frame builder, baud generator, transmit path and DMA requests.
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ufb_dev #(
   parameter int DIV_W = ufb_pkg::DIV_W
) (
   input wire logic mclk,
   input wire logic srst,
   ufb_if.dev bus,
   output logic tx_pin,
   output logic serial_clock_pin,
   input wire logic cts_n,
   input wire logic rx_pin,
   output logic rx_line,
   output logic os_tick,
   input wire logic rx_word_valid,
   input wire logic [ufb_pkg::DATA_W-1:0] rx_word,
   output logic tx_empty_irq
);
   import ufb_pkg::*;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ufb_tx_state_t;

   // =====================================================
   // Parameter check
   generate
      if (DIV_W < OS_SHIFT + 1 || DIV_W > 16) begin : g_bad
         $error("DIV_W out of range");
      end
   endgenerate

   // =====================================================
   // Frame helpers
   function automatic int nbits(input logic [1:0] dl);
      unique case (dl)
         DL_7: nbits = DBITS_7;
         DL_9: nbits = DBITS_9;
         default: nbits = DBITS_8;
      endcase
   endfunction : nbits

   function automatic logic [DATA_W-1:0] order(input logic [DATA_W-1:0] d, input int n, input logic msb);
      logic [DATA_W-1:0] r;
      r = d;
      if (msb) begin
         for (int i = 0; i < n; i++) begin
            r[i] = d[n-1-i];
         end
      end
      order = r;
   endfunction : order

   function automatic logic [DATA_W-1:0] build(input logic [DATA_W-1:0] w, input logic [31:0] c);
      logic [DATA_W-1:0] d;
      logic p;
      int n;
      d = '0;
      n = nbits(c[C_DLEN+:2]);
      p = c[C_ODD];
      for (int i = 0; i < DATA_W; i++) begin
         if (i < n - 1 || (i == n - 1 && !c[C_PAR])) begin
            d[i] = w[i];
            p = p ^ w[i];
         end
      end
      if (c[C_PAR]) begin
         d[n-1] = p;
      end
      if (c[C_DINV]) begin
         d = ~d;
      end
      build = order(d, n, c[C_MSB]);
   endfunction : build

   // =====================================================
   // Register port
   logic [31:0] ctrl_reg;
   logic [DIV_W-1:0] div_reg;
   logic txe_reg, txc_reg, baud_ev_reg, rxf_reg, perr_reg, stat_read_reg;
   logic [DATA_W-1:0] hold_reg, rxw_reg;
   logic txon_d_reg, rxon_d_reg, pend_idle_reg;
   logic wr_ctrl, wr_baud, wr_stat, wr_data, rd_stat, rd_data;
   logic load, brk_start, frame_end, run, half_tick;
   logic [DATA_W-1:0] rx_fix;
   int rx_n;

   assign wr_ctrl = bus.reg_wr && bus.reg_addr == IDX_CTRL;
   assign wr_baud = bus.reg_wr && bus.reg_addr == IDX_BAUD;
   assign wr_stat = bus.reg_wr && bus.reg_addr == IDX_STAT;
   assign wr_data = bus.reg_wr && bus.reg_addr == IDX_DATA;
   assign rd_stat = bus.reg_rd && bus.reg_addr == IDX_STAT;
   assign rd_data = bus.reg_rd && bus.reg_addr == IDX_DATA;
   assign bus.ctrl_view = ctrl_reg;
   assign bus.tx_done = txc_reg;

   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= bus.reg_wdata;
      end else if (brk_start) begin
         ctrl_reg[C_BRK] <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         div_reg <= DIV_W'(DIV_RESET);
      end else if (wr_baud) begin
         div_reg <= bus.reg_wdata[DIV_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         bus.reg_rdata <= '0;
         bus.reg_rvalid <= 1'b0;
      end else begin
         bus.reg_rvalid <= bus.reg_rd;
         unique case (bus.reg_addr)
            IDX_CTRL: bus.reg_rdata <= ctrl_reg;
            IDX_BAUD: bus.reg_rdata <= 32'(div_reg);
            IDX_STAT: bus.reg_rdata <= 32'({perr_reg, rxf_reg, baud_ev_reg, txc_reg, txe_reg});
            IDX_DATA: bus.reg_rdata <= 32'(rxw_reg);
         endcase
      end
   end

   // =====================================================
   // Status flags
   always_ff @(posedge mclk) begin
      if (srst) begin
         txe_reg <= TXE_RESET;
      end else if (wr_data) begin
         txe_reg <= 1'b0;
      end else if (load) begin
         txe_reg <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         hold_reg <= '0;
      end else if (wr_data) begin
         hold_reg <= bus.reg_wdata[DATA_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         stat_read_reg <= 1'b0;
      end else if (wr_data) begin
         stat_read_reg <= 1'b0;
      end else if (rd_stat) begin
         stat_read_reg <= 1'b1;
      end
   end

   // A frame ending in the clearing cycle keeps the flag set.
   always_ff @(posedge mclk) begin
      if (srst) begin
         txc_reg <= TXC_RESET;
      end else if (frame_end && txe_reg && !pend_idle_reg && !ctrl_reg[C_BRK]) begin
         txc_reg <= 1'b1;
      end else if ((wr_data && stat_read_reg) || (wr_stat && !bus.reg_wdata[S_TXC] && ctrl_reg[C_TXDMA])) begin
         txc_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         txon_d_reg <= 1'b0;
         rxon_d_reg <= 1'b0;
         baud_ev_reg <= 1'b0;
      end else begin
         txon_d_reg <= ctrl_reg[C_TXON];
         rxon_d_reg <= ctrl_reg[C_RXON];
         if ((txon_d_reg && !ctrl_reg[C_TXON]) || (rxon_d_reg && !ctrl_reg[C_RXON])) begin
            baud_ev_reg <= 1'b1;
         end else if (wr_stat && !bus.reg_wdata[S_BAUD]) begin
            baud_ev_reg <= 1'b0;
         end
      end
   end

   // =====================================================
   // Receive word capture, DMA and interrupt requests
   always_comb begin
      rx_n = nbits(ctrl_reg[C_DLEN+:2]);
      rx_fix = order(rx_word, rx_n, ctrl_reg[C_MSB]);
      if (ctrl_reg[C_DINV]) begin
         rx_fix = ~rx_fix;
      end
      for (int i = 0; i < DATA_W; i++) begin
         if (i >= rx_n) begin
            rx_fix[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rxw_reg <= '0;
         rxf_reg <= 1'b0;
         perr_reg <= 1'b0;
      end else begin
         if (rx_word_valid) begin
            rxw_reg <= rx_fix;
            rxf_reg <= 1'b1;
         end else if (rd_data) begin
            rxf_reg <= 1'b0;
         end
         if (rx_word_valid && ctrl_reg[C_PAR] && ((^rx_fix) != ctrl_reg[C_ODD])) begin
            perr_reg <= 1'b1;
         end else if (wr_stat && !bus.reg_wdata[S_PERR]) begin
            perr_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         bus.tx_dma_req <= 1'b0;
         bus.rx_dma_req <= 1'b0;
         tx_empty_irq <= 1'b0;
         rx_line <= 1'b1;
      end else begin
         bus.tx_dma_req <= ctrl_reg[C_TXDMA] && ctrl_reg[C_PERIPH] && txe_reg && !wr_data;
         bus.rx_dma_req <= ctrl_reg[C_RXDMA] && ctrl_reg[C_PERIPH] && rxf_reg && !rd_data;
         tx_empty_irq <= txe_reg && ctrl_reg[C_TXIE];
         rx_line <= rx_pin ^ ctrl_reg[C_RXINV];
      end
   end

   // =====================================================
   // Baud generator
   // The divisor is not re-read mid-bit safely, so the controller refuses divisor writes while C_PERIPH is set.
   logic [DIV_W-1:0] cnt_reg, div_m1, div_h1;
   logic [DIV_W-OS_SHIFT-1:0] os_cnt_reg, os_m1;

   assign run = ctrl_reg[C_PERIPH] && (ctrl_reg[C_TXON] || ctrl_reg[C_RXON]);
   assign div_m1 = div_reg - DIV_W'(1);
   assign div_h1 = (div_reg >> 1) - DIV_W'(1);
   assign os_m1 = div_reg[DIV_W-1:OS_SHIFT] - (DIV_W-OS_SHIFT)'(1);
   assign half_tick = run && (cnt_reg == div_m1 || cnt_reg == div_h1);

   always_ff @(posedge mclk) begin
      if (srst || !run) begin
         cnt_reg <= '0;
      end else if (cnt_reg == div_m1) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + DIV_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst || !run || cnt_reg == div_m1 || os_cnt_reg == os_m1) begin
         os_cnt_reg <= '0;
      end else begin
         os_cnt_reg <= os_cnt_reg + (DIV_W-OS_SHIFT)'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         os_tick <= 1'b0;
      end else begin
         os_tick <= run && os_cnt_reg == os_m1;
      end
   end

   // =====================================================
   // Transmit engine, counted in half bits so half stop bits fit.
   ufb_tx_state_t st_reg;
   logic [DATA_W-1:0] shift_reg;
   logic [3:0] left_reg;
   logic [2:0] stop_reg, stop_halves;
   logic half_reg, line_reg, go;

   always_comb begin
      unique case (ctrl_reg[C_STOP+:2])
         SB_HALF: stop_halves = HB_HALF;
         SB_2: stop_halves = HB_2;
         SB_1H: stop_halves = HB_1H;
         default: stop_halves = HB_1;
      endcase
   end

   assign go = st_reg == TX_IDLE && half_tick && ctrl_reg[C_PERIPH] && ctrl_reg[C_TXON]
      && !(ctrl_reg[C_CTS] && cts_n)
      && (pend_idle_reg || ctrl_reg[C_BRK] || !txe_reg);
   assign load = go && !pend_idle_reg && !ctrl_reg[C_BRK];
   assign brk_start = go && !pend_idle_reg && ctrl_reg[C_BRK];
   assign frame_end = st_reg == TX_STOP && half_tick && stop_reg == 3'h1;

   always_ff @(posedge mclk) begin
      if (srst) begin
         pend_idle_reg <= 1'b0;
      end else if (ctrl_reg[C_TXON] && !txon_d_reg) begin
         pend_idle_reg <= 1'b1;
      end else if (go) begin
         pend_idle_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst || !ctrl_reg[C_TXON] || !ctrl_reg[C_PERIPH]) begin
         st_reg <= TX_IDLE;
         line_reg <= 1'b1;
         half_reg <= 1'b0;
         shift_reg <= '0;
         left_reg <= '0;
         stop_reg <= '0;
      end else begin
         unique case (st_reg)
            TX_IDLE: begin
               line_reg <= 1'b1;
               if (go) begin
                  st_reg <= TX_START;
                  half_reg <= 1'b0;
                  left_reg <= 4'(nbits(ctrl_reg[C_DLEN+:2]) - 1);
                  if (pend_idle_reg) begin
                     line_reg <= 1'b1;
                     shift_reg <= '1;
                  end else if (ctrl_reg[C_BRK]) begin
                     line_reg <= 1'b0;
                     shift_reg <= '0;
                     left_reg <= 4'(nbits(ctrl_reg[C_DLEN+:2]));
                  end else begin
                     line_reg <= 1'b0;
                     shift_reg <= build(hold_reg, ctrl_reg);
                  end
               end
            end
            TX_START, TX_DATA: begin
               if (half_tick) begin
                  half_reg <= !half_reg;
                  if (half_reg) begin
                     if (st_reg == TX_DATA && left_reg == 4'h0) begin
                        st_reg <= TX_STOP;
                        line_reg <= 1'b1;
                        stop_reg <= stop_halves;
                     end else begin
                        if (st_reg == TX_DATA) begin
                           left_reg <= left_reg - 4'h1;
                        end
                        st_reg <= TX_DATA;
                        line_reg <= shift_reg[0];
                        shift_reg <= shift_reg >> 1;
                     end
                  end
               end
            end
            TX_STOP: begin
               if (half_tick) begin
                  if (stop_reg == 3'h1) begin
                     st_reg <= TX_IDLE;
                  end
                  stop_reg <= stop_reg - 3'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         tx_pin <= 1'b1;
         serial_clock_pin <= 1'b0;
      end else begin
         tx_pin <= line_reg ^ ctrl_reg[C_TXINV];
         serial_clock_pin <= ctrl_reg[C_CKOUT] && st_reg == TX_DATA && half_reg;
      end
   end
endmodule : ufb_dev
`default_nettype wire

// *** ufb_if.sv ***
// Connection between the serial slice and its controller.
`timescale 1ns/1ps
`default_nettype none
interface ufb_if;
   logic [1:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic reg_rvalid;
   logic tx_dma_req;
   logic rx_dma_req;
   logic tx_done;
   logic [31:0] ctrl_view;
   modport dev (input reg_addr, reg_wr, reg_rd, reg_wdata,
      output reg_rdata, reg_rvalid, tx_dma_req, rx_dma_req, tx_done, ctrl_view);
   modport ctl (output reg_addr, reg_wr, reg_rd, reg_wdata,
      input reg_rdata, reg_rvalid, tx_dma_req, rx_dma_req, tx_done, ctrl_view);
endinterface : ufb_if
`default_nettype wire

// *** ufb_link_checker.sv ***
// Assertions on the link between the serial slice and its controller.
`timescale 1ns/1ps
`default_nettype none
module ufb_link_checker import ufb_pkg::*; (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_rvalid,
   input wire logic tx_dma_req,
   input wire logic tx_done,
   input wire logic [31:0] ctrl_view
);
   // ==========
   // Link checks. A refused write that leaks through breaks several of these.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   a_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read unanswered");
   a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("stray answer");
   a_single_op: assert property (!(reg_wr && reg_rd))
      else $error("read and write together");
   a_dma_gate: assert property (tx_dma_req |-> $past(ctrl_view[C_TXDMA] && ctrl_view[C_PERIPH]))
      else $error("dma request ungated");
   a_baud_locked: assert property (reg_wr && reg_addr == IDX_BAUD |-> !ctrl_view[C_PERIPH])
      else $error("divisor changed while on");
   a_baud_floor: assert property (reg_wr && reg_addr == IDX_BAUD |-> reg_wdata[15:0] >= MIN_DIV)
      else $error("divisor below floor");
   a_done_clear: assert property ($fell(tx_done) |-> $past(reg_wr && reg_addr[1]))
      else $error("complete cleared without write");
   a_done_kept: assert property (reg_wr && reg_addr == IDX_STAT && tx_done && !ctrl_view[C_TXDMA] |=> tx_done)
      else $error("complete cleared without dma");
   a_txoff_guard: assert property ($fell(ctrl_view[C_TXON]) |-> $past(tx_done))
      else $error("transmitter off mid frame");
   c_dma_write: cover property (tx_dma_req ##1 reg_wr);
   c_done_fell: cover property ($fell(tx_done));
   c_tx_off: cover property ($fell(ctrl_view[C_TXON]));
endmodule : ufb_link_checker
`default_nettype wire

// *** ufb_pkg.sv ***
// Shared constants for the serial frame and baud slice and its controller.
package ufb_pkg;
   localparam int DIV_W = 16;
   localparam int DATA_W = 9;
   localparam int DBITS_7 = 7;
   localparam int DBITS_8 = 8;
   localparam int DBITS_9 = 9;
   localparam logic [1:0] IDX_CTRL = 2'h0;
   localparam logic [1:0] IDX_BAUD = 2'h1;
   localparam logic [1:0] IDX_STAT = 2'h2;
   localparam logic [1:0] IDX_DATA = 2'h3;
   localparam int C_PERIPH = 0;
   localparam int C_TXON = 1;
   localparam int C_RXON = 2;
   localparam int C_DLEN = 4;
   localparam int C_STOP = 6;
   localparam int C_PAR = 8;
   localparam int C_ODD = 9;
   localparam int C_MSB = 10;
   localparam int C_DINV = 11;
   localparam int C_TXINV = 12;
   localparam int C_RXINV = 13;
   localparam int C_TXDMA = 14;
   localparam int C_RXDMA = 15;
   localparam int C_TXIE = 16;
   localparam int C_BRK = 17;
   localparam int C_CKOUT = 18;
   localparam int C_CTS = 19;
   localparam int S_TXE = 0;
   localparam int S_TXC = 1;
   localparam int S_BAUD = 2;
   localparam int S_RXF = 3;
   localparam int S_PERR = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] DIV_RESET = 16'h0010;
   localparam logic [15:0] MIN_DIV = 16'h0010;
   localparam logic TXE_RESET = 1'b1;
   localparam logic TXC_RESET = 1'b1;
   localparam logic [1:0] DL_7 = 2'h2;
   localparam logic [1:0] DL_9 = 2'h1;
   localparam logic [1:0] SB_HALF = 2'h1;
   localparam logic [1:0] SB_2 = 2'h2;
   localparam logic [1:0] SB_1H = 2'h3;
   localparam logic [2:0] HB_1 = 3'h2;
   localparam logic [2:0] HB_HALF = 3'h1;
   localparam logic [2:0] HB_2 = 3'h4;
   localparam logic [2:0] HB_1H = 3'h3;
   localparam int OS_SHIFT = 4;
   localparam int AXI_AW = 5;
   localparam logic [4:0] A_DMA_TX = 5'h10;
   localparam logic [4:0] A_DMA_RX = 5'h14;
   localparam int A_LOCAL_BIT = 4;
   localparam int RXV_BIT = 31;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [3:0] STRB_ALL = 4'hf;
endpackage : ufb_pkg
